/* File: include/coal_pkg.sv */
// Constants and types shared by the notification coalescer
package coal_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_QUEUES = 4;       // Even index receive, odd index transmit
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int VQ_W       = 16;
  localparam int CODE_W     = 8;
  localparam int DIV_W      = 16;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CMD_OFF    = 8'h00;
  localparam logic [ADDR_W-1:0] VQ_OFF     = 8'h04;
  localparam logic [ADDR_W-1:0] PKTS_OFF   = 8'h08;
  localparam logic [ADDR_W-1:0] USECS_OFF  = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] DIV_OFF    = 8'h14;
  localparam logic [ADDR_W-1:0] QSTATE_OFF = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CMD_CLASS_LSB = 0;
  localparam int CMD_SUB_LSB   = 8;
  localparam int VQ_IDX_LSB    = 0;
  localparam int STAT_ERR_BIT  = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int QST_ACT_LSB   = 0;
  localparam int QST_PEND_LSB  = 8;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [CODE_W-1:0] CLASS_COAL = 8'h06;
  localparam logic [CODE_W-1:0] SUB_TX_ALL = 8'h00;
  localparam logic [CODE_W-1:0] SUB_RX_ALL = 8'h01;
  localparam logic [CODE_W-1:0] SUB_VQ_SET = 8'h02;
  localparam logic [CODE_W-1:0] SUB_VQ_GET = 8'h03;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] PARAM_RESET   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_ONE     = 32'h0000_0001;
  localparam int                CLK_PERIOD_NS = 5;
  localparam int                USEC_NS       = 1000;
  localparam int                TICK_CYCLES   = USEC_NS / CLK_PERIOD_NS;
  localparam logic [DIV_W-1:0]  DIV_RESET     = DIV_W'(TICK_CYCLES);
  localparam logic [DIV_W-1:0]  DIV_ONE       = 16'h0001;

  // Per-queue counting state
  typedef enum logic {Q_IDLE, Q_COUNT} q_state_e;

endpackage : coal_pkg

/* File: hw/notification_coalescer.sv */
// Per-queue notification coalescer with control-command register port
//
// Behaviour
// (RULE1) Decode class 6, subcommands zero to three
// (RULE2) Index is low 16 bits; reserved ignored
// (RULE3) Limits are 32-bit usecs and packets
// (RULE4) Class-wide set loads one direction only
// (RULE5) Per-queue set updates, get returns pair
// (RULE6) Latest written pair wins per queue
// (RULE7) Get fills the pair registers
// (RULE8) Notify once condition holds, unless suppressed
// (RULE9) Nonzero limits: first packet starts counting
// (RULE10) Met at usec limit or packet limit
// (RULE11) After met, idle until next packet
// (RULE12) Any zero limit: notify every packet
// (RULE13) Parameter change re-checks against live counts
// (RULE14) Unappliable set answers with error
// (RULE15) Bad or disabled index answers error
// (RULE16) Transmit re-enable reloads transmit-all pair
// (RULE17) Receive re-enable reloads receive-all pair
// (RULE18) Timing is best effort, tick granular
// (RULE19) Suppressed queues hold notification pending
// (RULE20) Reset clears every limit to zero
// (RULE21) Driver negotiates features before commands
// (RULE22) Driver names only enabled queues
// (RULE23) Driver drops pair on error answer
// (RULE24) Microsecond tick from programmable divider
//
// Design decisions made here: the address map and the strobed register port.
module notification_coalescer
(
  // Clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  // Register port
  input  wire logic [coal_pkg::ADDR_W-1:0]   addr,
  input  wire logic [coal_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  output logic      [coal_pkg::DATA_W-1:0]   rd_data,
  // Queue side
  input  wire logic [coal_pkg::NUM_QUEUES-1:0] q_enable,
  input  wire logic [coal_pkg::NUM_QUEUES-1:0] pkt_done,
  input  wire logic [coal_pkg::NUM_QUEUES-1:0] notify_suppressed,
  output logic      [coal_pkg::NUM_QUEUES-1:0] used_notify
);

  import coal_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] sub_q;
  logic [CODE_W-1:0] class_q;
  logic [DATA_W-1:0] vq_q;
  logic [DATA_W-1:0] pkts_q;
  logic [DATA_W-1:0] usecs_q;
  logic              err_q;
  logic              done_q;
  logic [DIV_W-1:0]  div_q;
  logic [DATA_W-1:0] tx_all_pkts_q;
  logic [DATA_W-1:0] tx_all_usecs_q;
  logic [DATA_W-1:0] rx_all_pkts_q;
  logic [DATA_W-1:0] rx_all_usecs_q;

  // Per-queue state
  logic [DATA_W-1:0] plim_q [NUM_QUEUES];
  logic [DATA_W-1:0] ulim_q [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] active;
  logic [NUM_QUEUES-1:0] pending;

  // Decode signals
  logic              cmd_go;
  logic [CODE_W-1:0] cmd_class;
  logic [CODE_W-1:0] cmd_sub;
  logic [VQ_W-1:0]   vq_idx;
  logic              idx_ok;
  logic              do_tx_all;
  logic              do_rx_all;
  logic              do_vq_set;
  logic              do_vq_get;
  logic              cmd_err;
  logic [DATA_W-1:0] sel_plim;
  logic [DATA_W-1:0] sel_ulim;

  // Microsecond tick
  logic [DIV_W-1:0]  div_cnt_q;
  logic              tick;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------

  // Writing the command word launches the command
  assign cmd_go    = ce && wr_en && (addr == CMD_OFF);
  assign cmd_class = wr_data[CMD_CLASS_LSB +: CODE_W];
  assign cmd_sub   = wr_data[CMD_SUB_LSB +: CODE_W];

  // (RULE2) low half only
  assign vq_idx = vq_q[VQ_IDX_LSB +: VQ_W];

  // (RULE15) index must name an enabled queue
  always_comb
  begin
    idx_ok   = 1'b0;
    sel_plim = PARAM_RESET;
    sel_ulim = PARAM_RESET;
    for (int i = 0; i < NUM_QUEUES; i++)
    begin
      if (vq_idx == VQ_W'(i) && q_enable[i])
      begin
        idx_ok   = 1'b1;
        sel_plim = plim_q[i];
        sel_ulim = ulim_q[i];
      end
    end
  end

  // (RULE1) class and subcommand decode
  assign do_tx_all = cmd_go && cmd_class == CLASS_COAL && cmd_sub == SUB_TX_ALL;
  assign do_rx_all = cmd_go && cmd_class == CLASS_COAL && cmd_sub == SUB_RX_ALL;
  assign do_vq_set = cmd_go && cmd_class == CLASS_COAL && cmd_sub == SUB_VQ_SET && idx_ok;
  assign do_vq_get = cmd_go && cmd_class == CLASS_COAL && cmd_sub == SUB_VQ_GET && idx_ok;

  // (RULE14) anything not applied answers error
  assign cmd_err = cmd_go && !(do_tx_all || do_rx_all || do_vq_set || do_vq_get);

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------

  // Last command word, kept for read-back
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      class_q <= '0;
      sub_q   <= '0;
    end
    else if (cmd_go)
    begin
      class_q <= cmd_class;
      sub_q   <= cmd_sub;
    end
  end

  // Index word, reserved half stored and only read back
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      vq_q <= '0;
    else if (ce && wr_en && addr == VQ_OFF)
      vq_q <= wr_data;
  end

  // (RULE7) parameter pair, filled by a get
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pkts_q  <= PARAM_RESET;
      usecs_q <= PARAM_RESET;
    end
    else if (do_vq_get)
    begin
      pkts_q  <= sel_plim;
      usecs_q <= sel_ulim;
    end
    else if (ce && wr_en && addr == PKTS_OFF)
      pkts_q <= wr_data;
    else if (ce && wr_en && addr == USECS_OFF)
      usecs_q <= wr_data;
  end

  // (RULE14) completion status of the last command
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      err_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else if (cmd_go)
    begin
      err_q  <= cmd_err;
      done_q <= 1'b1;
    end
  end

  // Class-wide pairs kept for queue re-enable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_all_pkts_q  <= PARAM_RESET;
      tx_all_usecs_q <= PARAM_RESET;
      rx_all_pkts_q  <= PARAM_RESET;
      rx_all_usecs_q <= PARAM_RESET;
    end
    else if (do_tx_all)
    begin
      tx_all_pkts_q  <= pkts_q;
      tx_all_usecs_q <= usecs_q;
    end
    else if (do_rx_all)
    begin
      rx_all_pkts_q  <= pkts_q;
      rx_all_usecs_q <= usecs_q;
    end
  end

  // ---------------------------------------------------------------
  // Microsecond tick
  // ---------------------------------------------------------------

  // Divider value, zero treated as one
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div_q <= DIV_RESET;
    else if (ce && wr_en && addr == DIV_OFF)
      div_q <= wr_data[DIV_W-1:0];
  end

  // (RULE24) one pulse every div_q cycles
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div_cnt_q <= '0;
    else if (ce)
    begin
      if (tick)
        div_cnt_q <= '0;
      else
        div_cnt_q <= div_cnt_q + DIV_ONE;
    end
  end

  // (RULE18) best effort, tick granular
  assign tick = ce && (div_cnt_q + DIV_ONE >= div_q);

  // ---------------------------------------------------------------
  // Per-queue coalescing
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_QUEUES; g++)
  begin : g_queue
    localparam bit IS_TX = (g % 2) == 1;

    logic              en_q;
    logic              load;
    logic              reload;
    logic [DATA_W-1:0] pkt_cnt_q;
    logic [DATA_W-1:0] usec_cnt_q;
    q_state_e          state_q;
    logic              zero_lim;
    logic              met;

    // (RULE4) class-wide set, this direction only
    // (RULE5) per-queue set hits the selected queue
    assign load = (IS_TX ? do_tx_all : do_rx_all)
                  || (do_vq_set && vq_idx == VQ_W'(g));

    // (RULE16) (RULE17) reload on enable rising
    assign reload = ce && q_enable[g] && !en_q;

    // Enable history for edge detect
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        en_q <= 1'b0;
      else if (ce)
        en_q <= q_enable[g];
    end

    // (RULE6) most recent write wins
    // (RULE20) limits reset to zero
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        plim_q[g] <= PARAM_RESET;
        ulim_q[g] <= PARAM_RESET;
      end
      else if (load)
      begin
        plim_q[g] <= pkts_q;
        ulim_q[g] <= usecs_q;
      end
      else if (reload)
      begin
        plim_q[g] <= IS_TX ? tx_all_pkts_q : rx_all_pkts_q;
        ulim_q[g] <= IS_TX ? tx_all_usecs_q : rx_all_usecs_q;
      end
    end

    // (RULE3) both limits compared as 32-bit counts
    assign zero_lim = (plim_q[g] == PARAM_RESET) || (ulim_q[g] == PARAM_RESET);

    // (RULE10) (RULE13) checked every cycle against live limits
    assign met = (state_q == Q_COUNT)
                 && (zero_lim || pkt_cnt_q >= plim_q[g] || usec_cnt_q >= ulim_q[g]);

    // (RULE9) (RULE11) (RULE12) counting state machine
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        state_q    <= Q_IDLE;
        pkt_cnt_q  <= PARAM_RESET;
        usec_cnt_q <= PARAM_RESET;
      end
      else if (ce)
      begin
        if (!q_enable[g])
        begin
          state_q    <= Q_IDLE;
          pkt_cnt_q  <= PARAM_RESET;
          usec_cnt_q <= PARAM_RESET;
        end
        else
        begin
          case (state_q)
            Q_IDLE:
            begin
              if (pkt_done[g] && !zero_lim)
              begin
                state_q    <= Q_COUNT;
                pkt_cnt_q  <= COUNT_ONE;
                usec_cnt_q <= PARAM_RESET;
              end
            end
            Q_COUNT:
            begin
              if (met)
                state_q <= Q_IDLE;
              else
              begin
                if (pkt_done[g])
                  pkt_cnt_q <= pkt_cnt_q + COUNT_ONE;
                if (tick)
                  usec_cnt_q <= usec_cnt_q + COUNT_ONE;
              end
            end
            default:
              state_q <= Q_IDLE;
          endcase
        end
      end
    end

    // (RULE19) condition held while suppressed, new event wins
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        pending[g] <= 1'b0;
      else if (ce)
      begin
        if (!q_enable[g])
          pending[g] <= 1'b0;
        else if (met || (pkt_done[g] && zero_lim))
          pending[g] <= 1'b1;
        else if (!notify_suppressed[g])
          pending[g] <= 1'b0;
      end
    end

    // (RULE8) one-cycle notification when allowed
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        used_notify[g] <= 1'b0;
      else if (ce)
        used_notify[g] <= pending[g] && q_enable[g] && !notify_suppressed[g];
    end

    assign active[g] = (state_q == Q_COUNT);
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------

  // Read data registered, unmapped reads give zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rd_data <= '0;
    else if (ce)
    begin
      rd_data <= '0;
      if (rd_en)
      begin
        case (addr)
          CMD_OFF:
          begin
            rd_data[CMD_CLASS_LSB +: CODE_W] <= class_q;
            rd_data[CMD_SUB_LSB +: CODE_W]   <= sub_q;
          end
          VQ_OFF:     rd_data <= vq_q;
          PKTS_OFF:   rd_data <= pkts_q;
          USECS_OFF:  rd_data <= usecs_q;
          STATUS_OFF:
          begin
            rd_data[STAT_ERR_BIT]  <= err_q;
            rd_data[STAT_DONE_BIT] <= done_q;
          end
          DIV_OFF:    rd_data[DIV_W-1:0] <= div_q;
          QSTATE_OFF:
          begin
            rd_data[QST_ACT_LSB +: NUM_QUEUES]  <= active;
            rd_data[QST_PEND_LSB +: NUM_QUEUES] <= pending;
          end
          default:    rd_data <= '0;
        endcase
      end
    end
  end

endmodule : notification_coalescer

/* File: bench/coal_chk_assertions.sv */
// Port assertions for the notification coalescer
module coal_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire logic [coal_pkg::ADDR_W-1:0] addr,
  input wire logic [coal_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [coal_pkg::DATA_W-1:0] rd_data,
  // Queue side
  input wire logic [coal_pkg::NUM_QUEUES-1:0] q_enable,
  input wire logic [coal_pkg::NUM_QUEUES-1:0] pkt_done,
  input wire logic [coal_pkg::NUM_QUEUES-1:0] notify_suppressed,
  input wire logic [coal_pkg::NUM_QUEUES-1:0] used_notify
);
  timeunit 1ns;
  timeprecision 100ps;
  import coal_pkg::*;

  logic [DATA_W-1:0] vq_q;
  logic cmd_w;
  logic st_rd;
  logic vq_sub;
  logic vq_bad;

  // Last index written by software
  always_ff @(posedge clk or posedge reset)
    if (reset)
      vq_q <= '0;
    else if (ce && wr_en && addr == VQ_OFF)
      vq_q <= wr_data;

  // Command launch, status read, index check
  assign cmd_w = ce && wr_en && addr == CMD_OFF;
  assign st_rd = ce && rd_en && addr == STATUS_OFF;
  assign vq_sub = wr_data[7:0] == CLASS_COAL && wr_data[15:8] inside {SUB_VQ_SET, SUB_VQ_GET};
  assign vq_bad = vq_q[15:0] >= 16'(NUM_QUEUES) || !q_enable[vq_q[1:0]];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  reset_quiet_a: assert property ($fell(reset) |-> rd_data == '0 && used_notify == '0)
    else $error("outputs busy after reset");
  read_idle_a: assert property (ce && !rd_en |=> rd_data == '0)
    else $error("read data outside read");
  supp_hold_a: assert property (ce |=> (used_notify & $past(notify_suppressed)) == '0)
    else $error("notify while suppressed");
  off_quiet_a: assert property (ce && $past(ce) |=> (used_notify & ~$past(q_enable) & ~$past(q_enable, 2)) == '0)
    else $error("notify on disabled queue");
  done_flag_a: assert property (cmd_w ##1 !wr_en ##1 st_rd |=> rd_data[STAT_DONE_BIT])
    else $error("done flag missing");
  bad_class_a: assert property (cmd_w && wr_data[7:0] != CLASS_COAL ##1 !wr_en ##1 st_rd |=> rd_data[STAT_ERR_BIT])
    else $error("foreign class accepted");
  bad_index_a: assert property (cmd_w && vq_sub && vq_bad ##1 !wr_en ##1 st_rd |=> rd_data[STAT_ERR_BIT])
    else $error("bad index accepted");
  good_index_a: assert property (cmd_w && vq_sub && !vq_bad ##1 !wr_en ##1 st_rd |=> !rd_data[STAT_ERR_BIT])
    else $error("good index refused");
  class_ok_a: assert property (cmd_w && wr_data[7:0] == CLASS_COAL && wr_data[15:8] <= SUB_RX_ALL
    ##1 !wr_en ##1 st_rd |=> !rd_data[STAT_ERR_BIT])
    else $error("class-wide set refused");
endmodule : coal_chk

bind notification_coalescer coal_chk coal_chk_i (
  .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .q_enable(q_enable), .pkt_done(pkt_done),
  .notify_suppressed(notify_suppressed), .used_notify(used_notify)
);

/* File: bench/drv.sv */
// Software model issuing coalescing commands
module drv (
  // Clock
  input wire logic clk,
  // Register port
  output logic [coal_pkg::ADDR_W-1:0] addr,
  output logic [coal_pkg::DATA_W-1:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [coal_pkg::DATA_W-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import coal_pkg::*;

  // Idle bus at time zero
  initial
  begin
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'h0;
    rd_en = 1'h0;
  end

  // One-cycle write, lines inverted after
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    addr <= ~a;
    wr_data <= ~d;
  endtask : wr

  // One-cycle read, data in next cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    addr <= ~a;
    #1 d = rd_data;
  endtask : rd

  task automatic cmd(input logic [7:0] sub, cls, output logic [DATA_W-1:0] st);
    wr(CMD_OFF, {16'h0000, sub, cls});
    rd(STATUS_OFF, st);
  endtask : cmd

  task automatic put(input logic [DATA_W-1:0] vq, pk, us, input logic [7:0] sub, output logic [DATA_W-1:0] st);
    wr(VQ_OFF, vq);
    wr(PKTS_OFF, pk);
    wr(USECS_OFF, us);
    cmd(sub, CLASS_COAL, st);
  endtask : put

  task automatic get(input logic [DATA_W-1:0] vq, output logic [DATA_W-1:0] st, pk, us);
    wr(VQ_OFF, vq);
    cmd(SUB_VQ_GET, CLASS_COAL, st);
    rd(PKTS_OFF, pk);
    rd(USECS_OFF, us);
    if (st[STAT_ERR_BIT])
    begin
      pk = '0;
      us = '0;
    end
  endtask : get
endmodule : drv

/* File: bench/notification_coalescer_tb_top.sv */
// Self-checking bench for the notification coalescer
module notification_coalescer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import coal_pkg::*;

  // --------
  // Signals
  // --------
  logic clk;
  logic reset;
  logic ce;
  logic wr_en;
  logic rd_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, vq, s, p, u, tp, tu, rp, ru;
  logic [DATA_W-1:0] ep [NUM_QUEUES];
  logic [DATA_W-1:0] eu [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] q_en, pkt, sup, note;
  logic [23:0] tbl [5] = '{24'h050000, 24'h060400, 24'h060204, 24'h060303, 24'h060302};
  int mismatches;
  int checked;
  int nc [NUM_QUEUES];

  notification_coalescer notification_coalescer_i (
    .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .q_enable(q_en), .pkt_done(pkt),
    .notify_suppressed(sup), .used_notify(note)
  );
  drv drv_i (
    .clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data)
  );

  // Clock, 5 ns period
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Notification pulses counted mid-cycle
  always @(negedge clk)
    foreach (nc[i])
      nc[i] += note[i];

  // Expected error flag of a command
  function automatic logic exp_err(input logic [7:0] cls, sub, input logic [DATA_W-1:0] v,
                                   input logic [NUM_QUEUES-1:0] en);
    if (cls != CLASS_COAL || sub > SUB_VQ_GET)
      return 1'h1;
    if (sub < SUB_VQ_SET)
      return 1'h0;
    return v[15:0] >= 16'(NUM_QUEUES) || !en[v[1:0]];
  endfunction : exp_err

  // Compare and count
  task automatic chk(input logic [95:0] g, e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Packet pulses on one queue
  task automatic send(input int q, n);
    repeat (n)
    begin
      @(posedge clk);
      pkt[q] <= 1'h1;
      @(posedge clk);
      pkt[q] <= 1'h0;
    end
  endtask : send

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // Read back every queue's pair
  task automatic all_pairs;
    for (int q = 0; q < NUM_QUEUES; q++)
    begin
      drv_i.get(32'(q), s, p, u);
      chk({s[1:0], p, u}, q_en[q] ? {2'h2, ep[q], eu[q]} : {2'h3, 64'h0});
    end
  endtask : all_pairs

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial
  begin
    #50000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    reset = 1'h1;
    ce = 1'h1;
    q_en = 4'hF;
    pkt = 4'h0;
    sup = 4'h0;
    ep = '{default: '0};
    eu = '{default: '0};
    s = $urandom(34);
    idle(4);
    reset <= 1'h0;
    drv_i.rd(DIV_OFF, s);
    chk(s, 96'(DIV_RESET));
    all_pairs();
    $display("test reset done");
    tp = $urandom;
    tu = $urandom;
    rp = $urandom;
    ru = $urandom;
    drv_i.put($urandom, tp, tu, SUB_TX_ALL, s);
    drv_i.put($urandom, rp, ru, SUB_RX_ALL, s);
    foreach (ep[q])
    begin
      ep[q] = q[0] ? tp : rp;
      eu[q] = q[0] ? tu : ru;
    end
    ep[0] = $urandom;
    drv_i.put({16'($urandom), 16'h0000}, ep[0], eu[0], SUB_VQ_SET, s);
    all_pairs();
    tp = $urandom;
    drv_i.put(32'h0, tp, tu, SUB_TX_ALL, s);
    ep[1] = tp;
    ep[3] = tp;
    all_pairs();
    $display("test set done");
    idle(1);
    q_en <= 4'h7;
    foreach (tbl[i])
    begin
      vq = {16'($urandom), 8'h00, tbl[i][7:0]};
      drv_i.wr(VQ_OFF, vq);
      drv_i.cmd(tbl[i][15:8], tbl[i][23:16], s);
      chk(s[1:0], {1'h1, exp_err(tbl[i][23:16], tbl[i][15:8], vq, q_en)});
    end
    all_pairs();
    drv_i.rd(CMD_OFF, s);
    chk(s, 96'h306);
    for (int q = 0; q < 2; q++)
    begin
      drv_i.put(32'(q), $urandom, $urandom, SUB_VQ_SET, s);
      idle(1);
      q_en[q] <= 1'h0;
      idle(1);
      q_en <= 4'hF;
      ep[q] = q ? tp : rp;
      eu[q] = q ? tu : ru;
    end
    all_pairs();
    $display("test errors done");
    drv_i.wr(DIV_OFF, 32'h2);
    // Enable low: write must be ignored
    ce <= 1'h0;
    drv_i.wr(DIV_OFF, 32'h7);
    ce <= 1'h1;
    drv_i.rd(DIV_OFF, s);
    chk(s, 96'h2);
    drv_i.put(32'h2, 32'h0, 32'h5, SUB_VQ_SET, s);
    nc = '{default: 0};
    send(2, 3);
    idle(4);
    chk(96'(nc[2]), 96'h3);
    sup <= 4'h4;
    send(2, 1);
    idle(8);
    chk(96'(nc[2]), 96'h3);
    sup <= 4'h0;
    idle(4);
    chk(96'(nc[2]), 96'h4);
    drv_i.put(32'h3, 32'h3, 32'hFFFF, SUB_VQ_SET, s);
    send(3, 2);
    idle(6);
    chk(96'(nc[3]), 96'h0);
    drv_i.rd(QSTATE_OFF, s);
    chk(s, 96'h8);
    send(3, 1);
    idle(4);
    chk(96'(nc[3]), 96'h1);
    idle(20);
    chk(96'(nc[3]), 96'h1);
    drv_i.put(32'h1, 32'hFFFF, 32'($urandom_range(6, 3)), SUB_VQ_SET, s);
    send(1, 1);
    idle(4);
    chk(96'(nc[1]), 96'h0);
    idle(12);
    chk(96'(nc[1]), 96'h1);
    drv_i.put(32'h3, 32'h64, 32'hFFFF, SUB_VQ_SET, s);
    send(3, 5);
    idle(4);
    chk(96'(nc[3]), 96'h1);
    drv_i.put(32'h3, 32'h3, 32'hFFFF, SUB_VQ_SET, s);
    idle(4);
    chk(96'(nc[3]), 96'h2);
    $display("test coalescing done");
    // Mid-run reset clears every written value but the divider, which returns to DIV_RESET
    reset <= 1'h1;
    idle(4);
    reset <= 1'h0;
    ep = '{default: '0};
    eu = '{default: '0};
    drv_i.rd(DIV_OFF, s);
    chk(s, 96'(DIV_RESET));
    all_pairs();
    $display("test second reset done");
    report_and_stop();
  end
endmodule : notification_coalescer_tb_top
